//--- hdl/ccasu_top.sv
// Carry chained signed add and subtract unit driven by an instruction sequencer
`timescale 1ns/1ps
module ccasu_top (
   input  wire logic                CLK,
   input  wire logic                RST_B,
   input  wire logic                EXEC,
   input  wire ccasu_pkg::ccasu_op_t OP_SEL,
   input  wire logic [15:0]         A_LO,
   input  wire logic [15:0]         A_HI,
   input  wire logic [15:0]         B_LO,
   input  wire logic [15:0]         B_HI,
   output logic      [15:0]         C_LO,
   output logic      [15:0]         C_HI,
   output logic                     C_HI_WE,
   output logic                     C_WE,
   output logic                     OVF,
   output logic                     CARRY_FLAG
);
   logic [15:0] c_lo_ff;
   logic [15:0] nxt_c_lo;
   logic [15:0] c_hi_ff;
   logic [15:0] nxt_c_hi;
   logic        c_we_ff;
   logic        nxt_c_we;
   logic        c_hi_we_ff;
   logic        nxt_c_hi_we;
   logic        ovf_ff;
   logic        nxt_ovf;
   logic        carry_flag_ff;
   logic        nxt_carry_flag;

   logic [15:0] lo_b;
   logic [15:0] lo_sum;
   logic        lo_cout;
   logic        lo_cmsb;
   logic [15:0] hi_sum;
   logic        hi_cout;
   logic        hi_cmsb;

   // Subtract is A plus not B plus not borrow-in; borrow is the inverted carry
   always_comb begin
      lo_b = (OP_SEL == ccasu_pkg::CCASU_OP_SUB16) ? ~B_LO : B_LO;
   end

   ccasu_word_add #(.W(ccasu_pkg::WORD_W)) u_lo (
      .a    (A_LO),
      .b    (lo_b),
      .cin  ((OP_SEL == ccasu_pkg::CCASU_OP_SUB16) ? ~carry_flag_ff : carry_flag_ff),
      .sum  (lo_sum),
      .cout (lo_cout),
      .cmsb (lo_cmsb)
   );

   // Upper word chained on the lower word carry
   ccasu_word_add #(.W(ccasu_pkg::WORD_W)) u_hi (
      .a    (A_HI),
      .b    (B_HI),
      .cin  (lo_cout),
      .sum  (hi_sum),
      .cout (hi_cout),
      .cmsb (hi_cmsb)
   );

   always_comb begin
      nxt_c_lo       = c_lo_ff;
      nxt_c_hi       = c_hi_ff;
      nxt_c_we       = 1'b0;
      nxt_c_hi_we    = 1'b0;
      nxt_ovf        = 1'b0;
      nxt_carry_flag = carry_flag_ff;
      if (EXEC) begin
         case (OP_SEL)
            ccasu_pkg::CCASU_OP_ADD16: begin
               nxt_c_lo       = lo_sum;
               nxt_c_we       = 1'b1;
               nxt_carry_flag = lo_cout;
               nxt_ovf        = lo_cout ^ lo_cmsb;
            end
            ccasu_pkg::CCASU_OP_SUB16: begin
               nxt_c_lo       = lo_sum;
               nxt_c_we       = 1'b1;
               nxt_carry_flag = ~lo_cout;
               nxt_ovf        = lo_cout ^ lo_cmsb;
            end
            ccasu_pkg::CCASU_OP_ADD32: begin
               nxt_c_lo       = lo_sum;
               nxt_c_hi       = hi_sum;
               nxt_c_we       = 1'b1;
               nxt_c_hi_we    = 1'b1;
               nxt_carry_flag = hi_cout;
               nxt_ovf        = hi_cout ^ hi_cmsb;
            end
            default: begin
               nxt_c_lo = c_lo_ff;
            end
         endcase
      end
   end

   always_ff @(posedge CLK) begin
      if (!RST_B) begin
         c_lo_ff       <= ccasu_pkg::WORD_RST;
         c_hi_ff       <= ccasu_pkg::WORD_RST;
         c_we_ff       <= 1'b0;
         c_hi_we_ff    <= 1'b0;
         ovf_ff        <= 1'b0;
         carry_flag_ff <= ccasu_pkg::CARRY_RST;
      end else begin
         c_lo_ff       <= nxt_c_lo;
         c_hi_ff       <= nxt_c_hi;
         c_we_ff       <= nxt_c_we;
         c_hi_we_ff    <= nxt_c_hi_we;
         ovf_ff        <= nxt_ovf;
         carry_flag_ff <= nxt_carry_flag;
      end
   end

   assign C_LO       = c_lo_ff;
   assign C_HI       = c_hi_ff;
   assign C_WE       = c_we_ff;
   assign C_HI_WE    = c_hi_we_ff;
   assign OVF        = ovf_ff;
   assign CARRY_FLAG = carry_flag_ff;

   // Reference arithmetic for checks
   logic signed [17:0] ref16;
   logic signed [33:0] ref32;
   always_comb begin
      ref16 = $signed({A_LO[15], A_LO[15], A_LO})
            + (OP_SEL == ccasu_pkg::CCASU_OP_SUB16
               ? -$signed({B_LO[15], B_LO[15], B_LO}) - $signed({17'h0_0000, carry_flag_ff})
               : $signed({B_LO[15], B_LO[15], B_LO}) + $signed({17'h0_0000, carry_flag_ff}));
      ref32 = $signed({A_HI[15], A_HI[15], A_HI, A_LO})
            + $signed({B_HI[15], B_HI[15], B_HI, B_LO})
            + $signed({33'h0_0000_0000, carry_flag_ff});
   end

   property p_idle;
      @(posedge CLK) disable iff (!RST_B)
      !EXEC |=> (!OVF && !C_WE && CARRY_FLAG == $past(CARRY_FLAG) && C_LO == $past(C_LO));
   endproperty
   a_idle: assert property (p_idle) else $error("Idle cycle changed state");

   property p_add16_sum;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD16) |=> (C_LO == $past(ref16[15:0]) && C_WE);
   endproperty
   a_add16_sum: assert property (p_add16_sum) else $error("Add16 sum wrong");

   property p_add16_carry;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD16)
         |=> CARRY_FLAG == $past(({1'b0, A_LO} + {1'b0, B_LO} + {16'h0000, carry_flag_ff}) > 17'h0_FFFF);
   endproperty
   a_add16_carry: assert property (p_add16_carry) else $error("Add16 carry wrong");

   property p_add16_ovf;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL != ccasu_pkg::CCASU_OP_ADD32 && OP_SEL != ccasu_pkg::CCASU_OP_NONE)
         |=> OVF == $past(ref16 > 18'sd32767 || ref16 < -18'sd32768);
   endproperty
   a_add16_ovf: assert property (p_add16_ovf) else $error("16-bit overflow wrong");

   property p_sub16_sum;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_SUB16) |=> C_LO == $past(ref16[15:0]);
   endproperty
   a_sub16_sum: assert property (p_sub16_sum) else $error("Sub16 difference wrong");

   property p_sub16_borrow;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_SUB16)
         |=> CARRY_FLAG == $past({1'b0, A_LO} < ({1'b0, B_LO} + {16'h0000, carry_flag_ff}));
   endproperty
   a_sub16_borrow: assert property (p_sub16_borrow) else $error("Sub16 borrow wrong");

   property p_add32;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD32)
         |=> ({C_HI, C_LO} == $past(ref32[31:0]) && C_HI_WE
              && OVF == $past(ref32 > 34'sd2147483647 || ref32 < -34'sd2147483648));
   endproperty
   a_add32: assert property (p_add32) else $error("Add32 result or overflow wrong");

   property p_add32_carry;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD32)
         |=> CARRY_FLAG == $past(({1'b0, A_HI, A_LO} + {1'b0, B_HI, B_LO}
                                 + {32'h0000_0000, carry_flag_ff}) > 33'h0_FFFF_FFFF);
   endproperty
   a_add32_carry: assert property (p_add32_carry) else $error("Add32 carry wrong");

   property p_sub16_ovf;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_SUB16)
         |=> OVF == $past(ref16 > 18'sd32767 || ref16 < -18'sd32768);
   endproperty
   a_sub16_ovf: assert property (p_sub16_ovf) else $error("Sub16 overflow wrong");

   property p_sub16_we;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_SUB16) |=> (C_WE && !C_HI_WE);
   endproperty
   a_sub16_we: assert property (p_sub16_we) else $error("Sub16 write pulse wrong");

   property p_hi_hold;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL != ccasu_pkg::CCASU_OP_ADD32) |=> (C_HI == $past(C_HI) && !C_HI_WE);
   endproperty
   a_hi_hold: assert property (p_hi_hold) else $error("High word changed by 16-bit op");

   property p_none_hold;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_NONE)
         |=> (!C_WE && !OVF && CARRY_FLAG == $past(CARRY_FLAG) && C_LO == $past(C_LO));
   endproperty
   a_none_hold: assert property (p_none_hold) else $error("No-op select changed state");

   property p_idle_hi;
      @(posedge CLK) disable iff (!RST_B)
      !EXEC |=> (!C_HI_WE && C_HI == $past(C_HI));
   endproperty
   a_idle_hi: assert property (p_idle_hi) else $error("Idle cycle changed high word");

   property p_add16_ovf_sign;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD16)
         |=> OVF == $past((A_LO[15] == B_LO[15]) && (ref16[15] != A_LO[15]));
   endproperty
   a_add16_ovf_sign: assert property (p_add16_ovf_sign) else $error("Add16 overflow rule");

   property p_sub16_ovf_sign;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_SUB16)
         |=> OVF == $past((A_LO[15] != B_LO[15]) && (ref16[15] != A_LO[15]));
   endproperty
   a_sub16_ovf_sign: assert property (p_sub16_ovf_sign) else $error("Sub16 overflow rule");

   property p_add32_ovf_sign;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD32)
         |=> OVF == $past((A_HI[15] == B_HI[15]) && (ref32[31] != A_HI[15]));
   endproperty
   a_add32_ovf_sign: assert property (p_add32_ovf_sign) else $error("Add32 overflow rule");

   property p_ovf_cause;
      @(posedge CLK) disable iff (!RST_B)
      OVF |-> $past(EXEC);
   endproperty
   a_ovf_cause: assert property (p_ovf_cause) else $error("Overflow without execution");

   property p_we_cause;
      @(posedge CLK) disable iff (!RST_B)
      C_WE |-> ($past(EXEC) && $past(OP_SEL) != ccasu_pkg::CCASU_OP_NONE);
   endproperty
   a_we_cause: assert property (p_we_cause) else $error("Write pulse without execution");

   property p_cf_cause;
      @(posedge CLK) disable iff (!RST_B)
      (CARRY_FLAG != $past(CARRY_FLAG)) |-> $past(EXEC);
   endproperty
   a_cf_cause: assert property (p_cf_cause) else $error("Carry flag changed while idle");

   property p_sub16_trunc;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_SUB16)
         |=> C_LO == $past(A_LO - B_LO - {15'h0000, carry_flag_ff});
   endproperty
   a_sub16_trunc: assert property (p_sub16_trunc) else $error("Sub16 not truncated");

   property p_add16_trunc;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD16)
         |=> C_LO == $past(A_LO + B_LO + {15'h0000, carry_flag_ff});
   endproperty
   a_add16_trunc: assert property (p_add16_trunc) else $error("Add16 not truncated");

   property p_add32_lo;
      @(posedge CLK) disable iff (!RST_B)
      (EXEC && OP_SEL == ccasu_pkg::CCASU_OP_ADD32)
         |=> (C_LO == $past(A_LO + B_LO + {15'h0000, carry_flag_ff}) && C_WE);
   endproperty
   a_add32_lo: assert property (p_add32_lo) else $error("Add32 low word wrong");

   property p_reset_clear;
      @(posedge CLK)
      !RST_B |=> (!CARRY_FLAG && !OVF && !C_WE && !C_HI_WE);
   endproperty
   a_reset_clear: assert property (p_reset_clear) else $error("Reset did not clear outputs");
endmodule

//--- hdl/ccasu_pkg.sv
// Package of operation codes and constants for the carry chain add/sub unit
package ccasu_pkg;
   localparam int unsigned WORD_W      = 16;
   localparam int unsigned MSB_POS     = 15;
   localparam int unsigned MSB_M1_POS  = 14;
   localparam logic        CARRY_RST   = 1'b0;
   localparam logic [15:0] WORD_RST    = 16'h0000;

   typedef enum logic [1:0] {
      CCASU_OP_ADD16 = 2'h0,
      CCASU_OP_SUB16 = 2'h1,
      CCASU_OP_ADD32 = 2'h2,
      CCASU_OP_NONE  = 2'h3
   } ccasu_op_t;
endpackage

//--- hdl/ccasu_word_add.sv
// 16-bit adder slice giving sum, carry out of bit 15 and carry into bit 15
`timescale 1ns/1ps
module ccasu_word_add #(
   parameter int unsigned W = 16
) (
   input  wire logic [W-1:0] a,
   input  wire logic [W-1:0] b,
   input  wire logic         cin,
   output logic      [W-1:0] sum,
   output logic              cout,
   output logic              cmsb
);
   logic [W-2:0] low_sum;
   logic         low_c;

   always_comb begin
      {low_c, low_sum} = {1'b0, a[W-2:0]} + {1'b0, b[W-2:0]} + {{(W-1){1'b0}}, cin};
      {cout, sum[W-1]} = {1'b0, a[W-1]} + {1'b0, b[W-1]} + {1'b0, low_c};
      sum[W-2:0]       = low_sum;
      cmsb             = low_c;
   end
endmodule

//--- dv/ccasu_seq_model.sv
// Sequencer model issuing one instruction per clock cycle
`timescale 1ns/1ps
module ccasu_seq_model (
   input  wire logic            CLK,
   output logic                 EXEC,
   output ccasu_pkg::ccasu_op_t OP_SEL,
   output logic [31:0]          A,
   output logic [31:0]          B
);
   initial begin
      EXEC = 1'b0;
      OP_SEL = ccasu_pkg::CCASU_OP_NONE;
      A = 32'h0000_0000;
      B = 32'h0000_0000;
   end

   // Operands, select and execute change together after a falling edge
   task automatic issue(input logic ex, input ccasu_pkg::ccasu_op_t op,
                        input logic [31:0] a, input logic [31:0] b);
      @(negedge CLK);
      EXEC = ex;
      OP_SEL = op;
      A = a;
      B = b;
      @(posedge CLK);
   endtask
endmodule

//--- dv/ccasu_top_tb.sv
// Self-checking testbench for the carry chain add/sub unit
`timescale 1ns/1ps
module ccasu_top_tb;
   logic                 clk;
   logic                 rst_b;
   wire logic            exec;
   ccasu_pkg::ccasu_op_t op_sel;
   wire logic [31:0]     a;
   wire logic [31:0]     b;
   logic [15:0]          c_lo;
   logic [15:0]          c_hi;
   logic                 c_hi_we;
   logic                 c_we;
   logic                 ovf;
   logic                 carry_flag;
   logic                 exp_cf;
   logic [15:0]          exp_lo;
   logic [15:0]          exp_hi;
   int                   err_total;
   int                   n_checks;

   ccasu_seq_model u_seq (.CLK(clk), .EXEC(exec), .OP_SEL(op_sel), .A(a), .B(b));
   ccasu_top dut (.CLK(clk), .RST_B(rst_b), .EXEC(exec), .OP_SEL(op_sel),
      .A_LO(a[15:0]), .A_HI(a[31:16]), .B_LO(b[15:0]), .B_HI(b[31:16]),
      .C_LO(c_lo), .C_HI(c_hi), .C_HI_WE(c_hi_we), .C_WE(c_we), .OVF(ovf),
      .CARRY_FLAG(carry_flag));

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic give_verdict;
      $display("Checks %0d, errors %0d", n_checks, err_total);
      if (err_total == 0 && n_checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic do_reset;
      @(negedge clk);
      rst_b = 1'b0;
      repeat (6) @(negedge clk);
      rst_b = 1'b1;
      exp_cf = 1'b0;
      exp_lo = 16'h0000;
      exp_hi = 16'h0000;
      chk("carry_flag", {31'h0, carry_flag}, 32'h0000_0000);
      chk("c_lo", {16'h0, c_lo}, 32'h0000_0000);
      chk("c_hi", {16'h0, c_hi}, 32'h0000_0000);
      chk("ovf", {31'h0, ovf}, 32'h0000_0000);
   endtask

   // One instruction, expectation built from signed arithmetic rules
   task automatic run(input logic ex, input ccasu_pkg::ccasu_op_t op,
                      input logic [31:0] av, input logic [31:0] bv);
      logic [32:0] r;
      logic        cy;
      logic        v;
      logic        w;
      w = ex && op != ccasu_pkg::CCASU_OP_NONE;
      r = 33'h0_0000_0000;
      cy = 1'b0;
      v = 1'b0;
      case (op)
         ccasu_pkg::CCASU_OP_ADD16: begin
            r = av[15:0] + bv[15:0] + exp_cf;
            cy = r[16];
            v = (av[15] == bv[15]) && (r[15] != av[15]);
         end
         ccasu_pkg::CCASU_OP_SUB16: begin
            r = av[15:0] - bv[15:0] - exp_cf;
            cy = r[16];
            v = (av[15] != bv[15]) && (r[15] != av[15]);
         end
         ccasu_pkg::CCASU_OP_ADD32: begin
            r = av + bv + exp_cf;
            cy = r[32];
            v = (av[31] == bv[31]) && (r[31] != av[31]);
         end
         default: w = 1'b0;
      endcase
      u_seq.issue(ex, op, av, bv);
      #1;
      if (w) begin
         exp_lo = r[15:0];
         exp_cf = cy;
         if (op == ccasu_pkg::CCASU_OP_ADD32) exp_hi = r[31:16];
      end
      chk("c_we", {31'h0, c_we}, {31'h0, w});
      chk("c_hi_we", {31'h0, c_hi_we}, {31'h0, w && op == ccasu_pkg::CCASU_OP_ADD32});
      chk("ovf", {31'h0, ovf}, {31'h0, w && v});
      chk("c_lo", {16'h0, c_lo}, {16'h0, exp_lo});
      chk("c_hi", {16'h0, c_hi}, {16'h0, exp_hi});
      chk("carry_flag", {31'h0, carry_flag}, {31'h0, exp_cf});
   endtask

   initial begin
      rst_b = 1'b0;
      err_total = 0;
      n_checks = 0;
      do_reset();
      run(1'b1, ccasu_pkg::CCASU_OP_ADD16, 32'h0000_8000, 32'h0000_D8F0);
      run(1'b1, ccasu_pkg::CCASU_OP_ADD16, 32'h0000_4E20, 32'h0000_7530);
      run(1'b1, ccasu_pkg::CCASU_OP_ADD16, 32'h0000_FFE7, 32'h0000_D8F0);
      run(1'b1, ccasu_pkg::CCASU_OP_SUB16, 32'h0000_5C60, 32'h0000_285F);
      run(1'b1, ccasu_pkg::CCASU_OP_SUB16, 32'h0000_B1E0, 32'h0000_7530);
      run(1'b1, ccasu_pkg::CCASU_OP_SUB16, 32'h0000_2710, 32'h0000_92A0);
      run(1'b1, ccasu_pkg::CCASU_OP_SUB16, 32'h0000_4005, 32'h0000_7918);
      run(1'b1, ccasu_pkg::CCASU_OP_ADD32, 32'h0BFB_8344, 32'h024C_DC8C);
      run(1'b1, ccasu_pkg::CCASU_OP_ADD32, 32'h8000_0000, 32'hFFFF_FFFF);
      run(1'b0, ccasu_pkg::CCASU_OP_ADD16, 32'h0000_7FFF, 32'h0000_7FFF);
      run(1'b1, ccasu_pkg::CCASU_OP_NONE, 32'h0000_1234, 32'h0000_4321);
      run(1'b1, ccasu_pkg::CCASU_OP_ADD16, 32'h0000_7FFF, 32'h0000_0000);
      do_reset();
      give_verdict();
   end

   initial begin
      repeat (2000) @(posedge clk);
      err_total++;
      give_verdict();
   end
endmodule
